//--- hw/sbi_shared_bus.v
// Shared bus interconnect: arbiter, address decoder, register write buffer, config slave
// Notes on behaviour
// - 32-bit address/data, three masters only
// - byte addresses; 8/16/32 singles, word bursts
// - boot map active after reset
// - normal map mirrors DDR at zero
// - map changes on read after write
// - 512 MB default, large enable gives 1 GB
// - fixed flash, registers, PCIe regions
// - 512 MB map layout per mode
// - 1 GB map layout per mode
// - protected soft reset keeps current map
// - strict programmable priority, processor highest at reset
// - weighted tokens; unused share goes elsewhere
// - reload token counters every refresh period
// - bus cycle spends token; empty drops low
// - token holders win; priority within groups
// - zero weight means unlimited tokens
// - priority level 15 is highest
// - one-word write buffer; stalls as needed
// - register read waits for buffered write to finish
// - subsystem registers fast, switch core slower
// - flash reads forwarded, flash writes dropped
`timescale 1ns/1ps
`include "sbi_consts.vh"
module sbi_shared_bus #(
  parameter TW = 16
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Subsystem soft reset and its protection
  input wire soft_rst,
  input wire system_protect,
  // Config slave, AHB-Lite
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Masters: 0 processor, 1 PCIe inbound, 2 bridge
  input wire [2:0] m_req,
  input wire [95:0] m_addr,
  input wire [2:0] m_write,
  input wire [5:0] m_size,
  input wire [95:0] m_wdata,
  input wire [2:0] m_burst,
  output wire [2:0] m_done,
  output reg [31:0] m_rdata,
  // Memory targets: flash boot reader, DDR, PCIe DMA
  output reg t_req,
  output reg [1:0] t_sel,
  output reg [31:0] t_addr,
  output reg t_write,
  output reg [1:0] t_size,
  output reg [31:0] t_wdata,
  input wire t_ack,
  input wire [31:0] t_rdata,
  // Chip register region
  output reg r_req,
  output reg r_write,
  output reg [27:0] r_addr,
  output reg [31:0] r_wdata,
  output reg r_switch_core,
  input wire r_ack,
  input wire [31:0] r_rdata
);
  localparam S_IDLE = 3'd0;
  localparam S_DEC = 3'd1;
  localparam S_EXT = 3'd2;
  localparam S_REG = 3'd3;
  localparam S_DONE = 3'd4;
  localparam G_RSV = 3'd0;
  localparam G_FLASH = 3'd1;
  localparam G_DDR = 3'd2;
  localparam G_PCIE = 3'd3;
  localparam G_REGS = 3'd4;

  // Only a soft reset without protection clears the subsystem
  wire srst = soft_rst & ~system_protect;

  // Config state
  reg boot_map_select_reg;
  reg boot_active_reg;
  reg large_memory_map_enable_reg;
  reg weighted_token_enable_reg;
  reg [11:0] prio_reg;
  reg [TW-1:0] token_refresh_period_reg;
  reg [TW-1:0] wt_reg [0:2];
  reg [TW-1:0] tok_cnt [0:2];
  reg [TW-1:0] per_cnt;

  // Transfer state
  reg [2:0] state_reg;
  reg [1:0] owner_reg;
  reg [31:0] wbuf_addr;
  reg [31:0] wbuf_data;
  reg wbuf_valid;
  reg rd_pend;

  // AHB bookkeeping
  reg ap_wr;
  reg ap_rd;
  reg [7:0] ap_off;
  reg rd_wait;

  integer i;
  integer j;
  integer k;

  // Arbitration
  reg [2:0] tok_ok;
  reg [1:0] win;
  reg [4:0] best;
  reg [4:0] score;
  reg found;
  always @* begin
    win = 2'd0;
    tok_ok = 3'b000;
    best = 5'h00;
    found = 1'b0;
    score = 5'h00;
    for (i = 0; i < 3; i = i + 1) begin
      tok_ok[i] = ~weighted_token_enable_reg | (wt_reg[i] == {TW{1'b0}}) | (tok_cnt[i] != {TW{1'b0}});
      score = {tok_ok[i], prio_reg[i*4 +: 4]};
      // Strict compare keeps the lower index on a tie
      if (m_req[i] && (!found || score > best)) begin
        win = i[1:0];
        best = score;
        found = 1'b1;
      end
    end
  end

  // Address decode for the current owner
  wire [31:0] a = m_addr[owner_reg*32 +: 32];
  wire cur_wr = m_write[owner_reg];
  reg [2:0] rg;
  reg [31:0] off;
  always @* begin
    rg = G_RSV;
    off = 32'h0000_0000;
    case (a[31:28])
      4'h0: rg = boot_active_reg ? G_FLASH : G_DDR;
      4'h1: rg = boot_active_reg ? G_RSV : G_DDR;
      4'h2, 4'h3: rg = (large_memory_map_enable_reg && boot_active_reg) ? G_RSV : G_DDR;
      `SBI_NIB_FLASH: rg = G_FLASH;
      `SBI_NIB_REGS: rg = G_REGS;
      4'h8, 4'h9, 4'hA, 4'hB: rg = large_memory_map_enable_reg ? G_DDR : G_RSV;
      4'hC, 4'hD, 4'hE, 4'hF: rg = G_PCIE;
      default: rg = G_RSV;
    endcase
    // Flash region is read only
    if (rg == G_FLASH && cur_wr)
      rg = G_RSV;
    case (rg)
      G_FLASH: off = {4'h0, a[27:0]};
      G_DDR: off = large_memory_map_enable_reg ? {2'b00, a[29:0]} : {3'b000, a[28:0]};
      G_PCIE: off = {2'b00, a[29:0]};
      default: off = a;
    endcase
  end

  wire reg_idle = ~r_req & ~wbuf_valid & ~rd_pend;

  // Transfer sequencing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      owner_reg <= 2'd0;
      m_rdata <= 32'h0000_0000;
      t_req <= 1'b0;
      t_sel <= 2'd0;
      t_addr <= 32'h0000_0000;
      t_write <= 1'b0;
      t_size <= 2'd0;
      t_wdata <= 32'h0000_0000;
      wbuf_valid <= 1'b0;
      wbuf_addr <= 32'h0000_0000;
      wbuf_data <= 32'h0000_0000;
      rd_pend <= 1'b0;
    end else if (srst) begin
      state_reg <= S_IDLE;
      t_req <= 1'b0;
      wbuf_valid <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      // Buffered write leaves once the register region acknowledges it (r_ack)
      if (wbuf_valid && r_req && r_write && r_ack)
        wbuf_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (m_req != 3'b000) begin
            owner_reg <= win;
            state_reg <= S_DEC;
          end
        end
        S_DEC: begin
          case (rg)
            G_FLASH, G_DDR, G_PCIE: begin
              t_req <= 1'b1;
              t_sel <= (rg == G_FLASH) ? `SBI_TGT_FLASH : (rg == G_DDR) ? `SBI_TGT_DDR : `SBI_TGT_PCIE;
              t_addr <= off;
              t_write <= cur_wr;
              t_size <= m_size[owner_reg*2 +: 2];
              t_wdata <= m_wdata[owner_reg*32 +: 32];
              state_reg <= S_EXT;
            end
            G_REGS: begin
              if (cur_wr) begin
                // Held here while the previous word is still buffered
                if (!wbuf_valid) begin
                  wbuf_valid <= 1'b1;
                  wbuf_addr <= a;
                  wbuf_data <= m_wdata[owner_reg*32 +: 32];
                  state_reg <= S_DONE;
                end
              end else if (reg_idle) begin
                rd_pend <= 1'b1;
                state_reg <= S_REG;
              end
            end
            default: begin
              m_rdata <= 32'h0000_0000;
              state_reg <= S_DONE;
            end
          endcase
        end
        S_EXT: begin
          if (t_ack) begin
            t_req <= 1'b0;
            m_rdata <= t_write ? 32'h0000_0000 : t_rdata;
            state_reg <= S_DONE;
          end
        end
        S_REG: begin
          if (r_req && !r_write && r_ack) begin
            rd_pend <= 1'b0;
            m_rdata <= r_rdata;
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          // Burst keeps the grant for the next beat
          state_reg <= m_burst[owner_reg] ? S_DEC : S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign m_done = (state_reg == S_DONE) ? (3'b001 << owner_reg) : 3'b000;

  // Register region port
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_req <= 1'b0;
      r_write <= 1'b0;
      r_addr <= 28'h000_0000;
      r_wdata <= 32'h0000_0000;
      r_switch_core <= 1'b0;
    end else if (srst) begin
      r_req <= 1'b0;
    end else if (r_req) begin
      if (r_ack)
        r_req <= 1'b0;
    end else if (wbuf_valid) begin
      r_req <= 1'b1;
      r_write <= 1'b1;
      r_addr <= wbuf_addr[27:0];
      r_wdata <= wbuf_data;
      r_switch_core <= wbuf_addr[27:24] != 4'h0;
    end else if (rd_pend) begin
      r_req <= 1'b1;
      r_write <= 1'b0;
      r_addr <= a[27:0];
      r_switch_core <= a[27:24] != 4'h0;
    end
  end

  // Token counters
  wire in_use = (state_reg != S_IDLE);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt <= {TW{1'b0}};
      for (j = 0; j < 3; j = j + 1)
        tok_cnt[j] <= {TW{1'b0}};
    end else if (srst) begin
      per_cnt <= {TW{1'b0}};
      for (j = 0; j < 3; j = j + 1)
        tok_cnt[j] <= {TW{1'b0}};
    end else if (per_cnt == {TW{1'b0}}) begin
      per_cnt <= (token_refresh_period_reg == {TW{1'b0}}) ? {TW{1'b0}} :
                 token_refresh_period_reg - {{(TW-1){1'b0}}, 1'b1};
      for (j = 0; j < 3; j = j + 1)
        tok_cnt[j] <= wt_reg[j];
    end else begin
      per_cnt <= per_cnt - {{(TW-1){1'b0}}, 1'b1};
      for (j = 0; j < 3; j = j + 1)
        if (in_use && owner_reg == j[1:0] && tok_cnt[j] != {TW{1'b0}})
          tok_cnt[j] <= tok_cnt[j] - {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // Config slave: writes take no wait, reads take one
  wire ap_valid = hsel & htrans[1] & hready;
  wire ctrl_wr = ap_wr & (ap_off == `SBI_OFF_CTRL);
  wire boot_now = ctrl_wr ? hwdata[`SBI_BIT_BOOT] : boot_map_select_reg;
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_off <= 8'h00;
      rd_wait <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      ap_wr <= ap_valid & hwrite;
      ap_rd <= ap_valid & ~hwrite;
      rd_wait <= ap_valid & ~hwrite;
      if (ap_valid)
        ap_off <= {haddr[7:2], 2'b00};
      if (ap_rd) begin
        case (ap_off)
          `SBI_OFF_CTRL: hrdata <= {29'h0, weighted_token_enable_reg, large_memory_map_enable_reg,
                                    boot_map_select_reg};
          `SBI_OFF_PRIO: hrdata <= {20'h0, prio_reg};
          `SBI_OFF_PERIOD: hrdata <= {{(32-TW){1'b0}}, token_refresh_period_reg};
          `SBI_OFF_WT_PROC: hrdata <= {{(32-TW){1'b0}}, wt_reg[0]};
          `SBI_OFF_PCIE_MASTER_TOKEN_WEIGHT: hrdata <= {{(32-TW){1'b0}}, wt_reg[1]};
          `SBI_OFF_WT_BRIDGE: hrdata <= {{(32-TW){1'b0}}, wt_reg[2]};
          `SBI_OFF_STATUS: hrdata <= {22'h0, owner_reg, 1'b0, tok_ok, 1'b0, wbuf_valid, in_use,
                                      boot_active_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Config registers; a protected soft reset leaves all of them alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_map_select_reg <= 1'b1;
      boot_active_reg <= 1'b1;
      large_memory_map_enable_reg <= 1'b0;
      weighted_token_enable_reg <= 1'b0;
      prio_reg <= {`SBI_RST_PL_BRIDGE, `SBI_RST_PCIE_MASTER_PRIORITY_LEVEL, `SBI_RST_PL_PROC};
      token_refresh_period_reg <= `SBI_RST_PERIOD;
      for (k = 0; k < 3; k = k + 1)
        wt_reg[k] <= `SBI_RST_WT;
    end else if (srst) begin
      boot_map_select_reg <= 1'b1;
      boot_active_reg <= 1'b1;
      large_memory_map_enable_reg <= 1'b0;
      weighted_token_enable_reg <= 1'b0;
      prio_reg <= {`SBI_RST_PL_BRIDGE, `SBI_RST_PCIE_MASTER_PRIORITY_LEVEL, `SBI_RST_PL_PROC};
      token_refresh_period_reg <= `SBI_RST_PERIOD;
      for (k = 0; k < 3; k = k + 1)
        wt_reg[k] <= `SBI_RST_WT;
    end else begin
      // The selected map only takes effect on the read-back
      if (ap_valid && !hwrite && haddr[7:0] == `SBI_OFF_CTRL)
        boot_active_reg <= boot_now;
      if (ap_wr) begin
        case (ap_off)
          `SBI_OFF_CTRL: begin
            boot_map_select_reg <= hwdata[`SBI_BIT_BOOT];
            large_memory_map_enable_reg <= hwdata[`SBI_BIT_LARGE];
            weighted_token_enable_reg <= hwdata[`SBI_BIT_WTEN];
          end
          `SBI_OFF_PRIO: prio_reg <= hwdata[11:0];
          `SBI_OFF_PERIOD: token_refresh_period_reg <= hwdata[TW-1:0];
          `SBI_OFF_WT_PROC: wt_reg[0] <= hwdata[TW-1:0];
          `SBI_OFF_PCIE_MASTER_TOKEN_WEIGHT: wt_reg[1] <= hwdata[TW-1:0];
          `SBI_OFF_WT_BRIDGE: wt_reg[2] <= hwdata[TW-1:0];
          default: ;
        endcase
      end
    end
  end

endmodule

//--- shared/sbi_consts.vh
// Constants for the shared bus interconnect
`ifndef SBI_CONSTS_VH
`define SBI_CONSTS_VH
// Configuration register byte offsets
`define SBI_OFF_CTRL 8'h00
`define SBI_OFF_PRIO 8'h04
`define SBI_OFF_PERIOD 8'h08
`define SBI_OFF_WT_PROC 8'h0C
`define SBI_OFF_PCIE_MASTER_TOKEN_WEIGHT 8'h10
`define SBI_OFF_WT_BRIDGE 8'h14
`define SBI_OFF_STATUS 8'h18
// Control register fields
`define SBI_BIT_BOOT 0
`define SBI_BIT_LARGE 1
`define SBI_BIT_WTEN 2
// Status register fields
`define SBI_BIT_ACT_BOOT 0
`define SBI_BIT_BUSY 1
`define SBI_BIT_WBUF 2
`define SBI_POS_TOKOK 4
`define SBI_POS_OWNER 8
// Priority register fields, four bits each
`define SBI_POS_PL_PROC 0
`define SBI_POS_PCIE_MASTER_PRIORITY_LEVEL 4
`define SBI_POS_PL_BRIDGE 8
// Reset values
`define SBI_RST_PL_PROC 4'hF
`define SBI_RST_PCIE_MASTER_PRIORITY_LEVEL 4'hE
`define SBI_RST_PL_BRIDGE 4'hD
`define SBI_RST_PERIOD 16'h0800
`define SBI_RST_WT 16'h0000
// Downstream target codes
`define SBI_TGT_FLASH 2'h0
`define SBI_TGT_DDR 2'h1
`define SBI_TGT_PCIE 2'h2
// Address map anchors (top nibble)
`define SBI_NIB_FLASH 4'h4
`define SBI_NIB_REGS 4'h7
`endif

//--- tb/sbi_far_model.sv
// Far-side responders: memory targets and chip register region
`timescale 1ns/1ps
module sbi_far_model (
  // Clock, reset, pace
  input wire hclk,
  input wire hresetn,
  input wire slow,
  // Memory targets
  input wire t_req,
  input wire [1:0] t_sel,
  input wire [31:0] t_addr,
  output reg t_ack,
  output reg [31:0] t_rdata,
  // Register region
  input wire r_req,
  input wire [27:0] r_addr,
  output reg r_ack,
  output reg [31:0] r_rdata
);
  reg [3:0] t_cnt_reg;
  reg [3:0] r_cnt_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_ack <= 1'b0;
      r_ack <= 1'b0;
      t_rdata <= 32'h0;
      r_rdata <= 32'h0;
      t_cnt_reg <= 4'h0;
      r_cnt_reg <= 4'h0;
    end else begin
      t_ack <= 1'b0;
      r_ack <= 1'b0;
      // Stale data flips each cycle so a sample one cycle late does not match
      t_rdata <= ~t_rdata;
      r_rdata <= ~r_rdata;
      t_cnt_reg <= (t_req && !t_ack) ? t_cnt_reg + 4'h1 : 4'h0;
      r_cnt_reg <= (r_req && !r_ack) ? r_cnt_reg + 4'h1 : 4'h0;
      if (t_req && !t_ack && t_cnt_reg >= (slow ? 4'h6 : 4'h0)) begin
        t_ack <= 1'b1;
        t_rdata <= {t_sel, t_addr[29:0]};
      end
      if (r_req && !r_ack && r_cnt_reg >= (slow ? 4'h9 : 4'h1)) begin
        r_ack <= 1'b1;
        r_rdata <= {4'hA, r_addr};
      end
    end
  end
endmodule

//--- tb/sbi_shared_bus_asserts.sv
// Port-level timing checks for the shared bus interconnect
`timescale 1ns/1ps
`include "sbi_consts.vh"
module sbi_shared_bus_asserts (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire soft_rst,
  // Config slave
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // Masters
  input wire [2:0] m_done,
  // Targets
  input wire t_req,
  input wire [1:0] t_sel,
  input wire [31:0] t_addr,
  input wire t_write,
  input wire t_ack,
  input wire r_req,
  input wire r_write,
  input wire [27:0] r_addr,
  input wire [31:0] r_wdata,
  input wire r_switch_core,
  input wire r_ack
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  read_wait_a: assert property (rd_taken |=> one_wait) else $error("read wait wrong");
  done_onehot_a: assert property ($onehot0(m_done)) else $error("done not one-hot");
  done_pulse_a: assert property (|m_done |=> m_done == 3'h0) else $error("done too long");
  ext_hold_a: assert property (t_req && !t_ack && !soft_rst |=> t_req && $stable(t_addr))
    else $error("target request unstable");
  reg_hold_a: assert property (r_req && !r_ack && !soft_rst |=> r_req && $stable(r_addr) && $stable(r_wdata))
    else $error("register request unstable");
  core_flag_a: assert property (r_req |-> r_switch_core == (r_addr[27:24] != 4'h0))
    else $error("core flag wrong");
  flash_nowrite_a: assert property (t_req |-> !(t_write && t_sel == `SBI_TGT_FLASH))
    else $error("flash written");
  ext_done_a: assert property (t_req && t_ack && !t_write |=> |m_done) else $error("late done");
  reg_done_a: assert property (r_req && r_ack && !r_write |=> |m_done) else $error("late reg done");
endmodule

//--- tb/sbi_shared_bus_test.sv
// Self-checking bench for the shared bus interconnect
`timescale 1ns/1ps
`include "sbi_consts.vh"
module sbi_shared_bus_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic soft_rst = 1'b0;
  logic system_protect = 1'b0;
  logic slow = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic chk_ord = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [2:0] m_req = 3'h0;
  logic [2:0] m_write = 3'h0;
  logic [2:0] m_burst = 3'h0;
  logic [95:0] m_addr = 96'h0;
  logic [95:0] m_wdata = 96'h0;
  logic [5:0] m_size = 6'h2A;
  logic ord_done = 1'b0;
  logic [1:0] t_sz_seen = 2'h0;
  logic [31:0] t_wd_seen = 32'h0;
  logic [31:0] r_wd_seen = 32'h0;
  wire hready, hreadyout, hresp, t_req, t_write, t_ack, r_req, r_write, r_switch_core, r_ack;
  wire [2:0] m_done;
  wire [1:0] t_sel, t_size;
  wire [27:0] r_addr;
  wire [31:0] hrdata, m_rdata, t_addr, t_wdata, t_rdata, r_wdata, r_rdata;
  int bad_count = 0;
  int comparisons = 0;
  int wacks = 0;
  assign hready = hreadyout;
  sbi_shared_bus dut_u (.hclk(hclk), .hresetn(hresetn), .soft_rst(soft_rst), .system_protect(system_protect),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .m_req(m_req), .m_addr(m_addr),
    .m_write(m_write), .m_size(m_size), .m_wdata(m_wdata), .m_burst(m_burst), .m_done(m_done),
    .m_rdata(m_rdata), .t_req(t_req), .t_sel(t_sel), .t_addr(t_addr), .t_write(t_write), .t_size(t_size),
    .t_wdata(t_wdata), .t_ack(t_ack), .t_rdata(t_rdata), .r_req(r_req), .r_write(r_write), .r_addr(r_addr),
    .r_wdata(r_wdata), .r_switch_core(r_switch_core), .r_ack(r_ack), .r_rdata(r_rdata));
  sbi_far_model far_u (.hclk(hclk), .hresetn(hresetn), .slow(slow), .t_req(t_req), .t_sel(t_sel),
    .t_addr(t_addr), .t_ack(t_ack), .t_rdata(t_rdata), .r_req(r_req), .r_addr(r_addr), .r_ack(r_ack),
    .r_rdata(r_rdata));
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Called right after a rising edge; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    // Ready and read data are sampled at the rising edge itself
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
    rd = hrdata;
    if (n > 50)
      bad_count++;
  endtask
  // Burst beats keep the request up across the done edge
  task mst(input int i, input logic [31:0] a, input logic w, input logic bu);
    int n;
    n = 0;
    m_addr[i*32+:32] <= a;
    m_wdata[i*32+:32] <= ~a;
    m_write[i] <= w;
    m_burst[i] <= bu;
    m_req[i] <= 1'b1;
    do @(negedge hclk); while (m_done[i] !== 1'b1 && n++ < 300);
    rd = m_rdata;
    if (n > 300)
      bad_count++;
    @(posedge hclk);
    if (!bu) begin
      m_req[i] <= 1'b0;
      @(posedge hclk);
    end
  endtask
  task mp(input logic [31:0] a, input logic [31:0] exp);
    mst(0, a, 1'b0, 1'b0);
    cmp(rd, exp);
  endtask
  task ctrl(input logic [31:0] v);
    ahb(1'b1, `SBI_OFF_CTRL, v);
    ahb(1'b0, `SBI_OFF_CTRL, 32'h0);
    cmp(rd, v);
  endtask
  // All three ask at once; the first done names the winner
  task contest(input logic [2:0] exp);
    int n;
    logic f;
    logic [2:0] d;
    n = 0;
    f = 1'b1;
    m_addr <= {3{32'h50000000}};
    m_write <= 3'h0;
    m_req <= 3'h7;
    do begin
      @(negedge hclk);
      d = m_done;
      if (f && |d) begin
        f = 1'b0;
        cmp(d, exp);
      end
      @(posedge hclk);
      m_req <= m_req & ~d;
    end while (m_req !== 3'h0 && n++ < 100);
    if (n > 100)
      bad_count++;
    @(posedge hclk);
  endtask
  task srst(input logic p);
    system_protect <= p;
    soft_rst <= 1'b1;
    @(posedge hclk);
    soft_rst <= 1'b0;
    @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    if (r_req && r_ack && r_write) begin
      wacks <= wacks + 1;
      r_wd_seen <= r_wdata;
    end
    if (t_req && t_ack) begin
      t_sz_seen <= t_size;
      t_wd_seen <= t_wdata;
    end
  end
  always @(negedge hclk) begin
    if (chk_ord && !ord_done && r_req && !r_write) begin
      ord_done = 1'b1;
      cmp(wacks, 2);
    end
  end
  initial forever #5 hclk = ~hclk;
  initial begin
    #200000;
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, `SBI_OFF_CTRL, 32'h0);
    cmp(rd, 32'h1);
    ahb(1'b0, `SBI_OFF_PRIO, 32'h0);
    cmp(rd, 32'hDEF);
    ahb(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h0);
    mp(32'h00000010, 32'h00000010);
    mp(32'h10000000, 32'h0);
    mp(32'h20000004, 32'h40000004);
    m_size <= 6'h28;
    mst(0, 32'h20000008, 1'b1, 1'b0);
    cmp(rd, 32'h0);
    cmp(t_sz_seen, 32'h0);
    cmp(t_wd_seen, 32'hDFFFFFF7);
    m_size <= 6'h2A;
    mp(32'h40000020, 32'h00000020);
    mp(32'h50000000, 32'h0);
    mp(32'h80000000, 32'h0);
    mp(32'hC0000100, 32'h80000100);
    mst(0, 32'h40000000, 1'b1, 1'b0);
    cmp(rd, 32'h0);
    ahb(1'b1, `SBI_OFF_CTRL, 32'h0);
    mp(32'h00000010, 32'h00000010);
    ctrl(32'h0);
    mp(32'h00000010, 32'h40000010);
    ctrl(32'h2);
    srst(1'b1);
    mp(32'h30000000, 32'h70000000);
    mp(32'h80000010, 32'h40000010);
    ctrl(32'h3);
    mp(32'h10000000, 32'h0);
    mst(0, 32'h70000000, 1'b0, 1'b1);
    cmp(rd, 32'hA0000000);
    mst(0, 32'h70000004, 1'b0, 1'b0);
    cmp(rd, 32'hA0000004);
    slow <= 1'b1;
    chk_ord <= 1'b1;
    mst(1, 32'h70000008, 1'b1, 1'b0);
    mst(1, 32'h71000008, 1'b1, 1'b0);
    mp(32'h71000010, 32'hA1000010);
    cmp(wacks, 2);
    cmp(r_wd_seen, 32'h8EFFFFF7);
    contest(3'h1);
    ahb(1'b1, `SBI_OFF_PRIO, 32'hF10);
    contest(3'h4);
    ahb(1'b1, `SBI_OFF_WT_BRIDGE, 32'h1);
    ahb(1'b1, `SBI_OFF_PERIOD, 32'hFFFF);
    ctrl(32'h4);
    // Outlast the old period so the new weight is loaded once
    repeat (2100) @(posedge hclk);
    contest(3'h4);
    contest(3'h2);
    mst(2, 32'h50000000, 1'b0, 1'b0);
    cmp(rd, 32'h0);
    contest(3'h2);
    srst(1'b0);
    ahb(1'b0, `SBI_OFF_CTRL, 32'h0);
    cmp(rd, 32'h1);
    give_verdict;
  end
endmodule
bind sbi_shared_bus sbi_shared_bus_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .soft_rst(soft_rst),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .m_done(m_done), .t_req(t_req), .t_sel(t_sel), .t_addr(t_addr), .t_write(t_write), .t_ack(t_ack),
  .r_req(r_req), .r_write(r_write), .r_addr(r_addr), .r_wdata(r_wdata), .r_switch_core(r_switch_core),
  .r_ack(r_ack));
